/* src/fuse_lock_config_store.sv */
// Contract
// (R1) 11 no boot limit; 10 blocks store
// (R2) 00 blocks store and app-side loads
// (R3) 01 allows store, blocks app-side loads
// (R4) read-blocking modes mask interrupts in boot
// (R5) programmed fuse reads as 0
// (R6) high fuse byte layout and defaults
// (R7) low fuse byte layout and defaults
// (R8) defaults: 1MHz rc, longest start-up
// (R9) serial port cannot touch serial enable
// (R10) chip erase keeps fuses, clears locks
// (R11) fuses frozen while first lock programmed
// (R12) programmer writes fuses before locks
// (R13) latch on programming entry, apply on exit
// (R14) preserve fuse acts at once when programmed
// (R15) latch fuses at power-up in normal mode
// (R16) preserve fuse keeps eeprom on erase
// (R17) three id bytes readable even locked
// (R18) four calibration bytes for 1/2/4/8 MHz
// (R19) reset loads 1MHz calibration automatically
// (R20) flash page 64 words, 128 pages
// (R21) eeprom page 4 bytes, 128 pages
`timescale 1ns/100ps
module fuse_lock_config_store
  import fuse_lock_pkg::*;
(
  // system
  input  wire logic        clock,
  input  wire logic        arst_n,
  // programmer side
  input  wire logic        prog_mode,
  input  wire logic        prog_serial,
  input  wire logic        prog_write,
  input  wire logic [1:0]  prog_target,
  input  wire logic [7:0]  prog_wdata,
  input  wire logic        chip_erase,
  input  wire logic [1:0]  id_addr,
  output logic      [7:0]  fuse_high_byte_rd,
  output logic      [7:0]  fuse_low_byte_rd,
  output logic      [7:0]  lock_rd,
  output logic      [7:0]  id_rd,
  output logic      [7:0]  cal_rd,
  output logic             write_refused,
  output logic             ee_erase,
  // core side
  input  wire logic [12:0] fetch_pc,
  input  wire logic [12:0] target_pc,
  input  wire logic        store_req,
  input  wire logic        load_req,
  input  wire logic        vectors_in_app,
  input  wire logic [8:0]  ee_addr,
  input  wire logic        trim_write,
  input  wire logic [7:0]  trim_wdata,
  output logic             store_allow,
  output logic             load_allow,
  output logic             irq_mask,
  output logic      [7:0]  oscillator_trim_register,
  output logic      [7:0]  fuse_high_active,
  output logic      [7:0]  fuse_low_active,
  output logic      [5:0]  flash_word_index,
  output logic      [6:0]  flash_page_index,
  output logic      [1:0]  ee_byte_index,
  output logic      [6:0]  ee_page_index
);

  logic [7:0]  fuse_high_byte;
  logic [7:0]  fuse_low_byte;
  logic [7:0]  lock_byte;
  logic        ee_preserve_now;
  logic        boot_pending;
  mode_e       mode;
  logic [12:0] boot_start;
  logic        fuse_wr_ok;
  logic        fetch_in_boot;
  logic        target_in_boot;
  logic        read_block_mode;
  logic        store_block_now;
  logic [7:0]  masked_high;

  function automatic logic in_boot(input logic [12:0] addr,
                                   input logic [12:0] start);
    return addr >= start;
  endfunction : in_boot

  // boot lock mode decode for stores, 1 = unprogrammed
  function automatic logic store_blocked(input logic upper,
                                         input logic lower);
    case ({upper, lower})
      2'h3:    return 1'b0; // see (R1)
      2'h2:    return 1'b1; // see (R1)
      2'h0:    return 1'b1; // see (R2)
      2'h1:    return 1'b0; // see (R3)
      default: return 1'b1;
    endcase
  endfunction : store_blocked

  // boot lock mode decode for app-side loads
  function automatic logic load_blocked(input logic upper,
                                        input logic lower);
    case ({upper, lower})
      2'h3:    return 1'b0; // see (R1)
      2'h2:    return 1'b0; // see (R1)
      2'h0:    return 1'b1; // see (R2)
      2'h1:    return 1'b1; // see (R3)
      default: return 1'b1;
    endcase
  endfunction : load_blocked

  // boot section start from active boot size
  always_comb begin
    case ({fuse_high_active[BOOT_SIZE_HI_BIT],
           fuse_high_active[BOOT_SIZE_LO_BIT]})
      2'h3:    boot_start = BOOT_START_3;
      2'h2:    boot_start = BOOT_START_2;
      2'h1:    boot_start = BOOT_START_1;
      default: boot_start = BOOT_START_0;
    endcase
  end

  assign fetch_in_boot  = in_boot(fetch_pc, boot_start);
  assign target_in_boot = in_boot(target_pc, boot_start);
  // modes 00 and 01 block reads
  assign read_block_mode = load_blocked(lock_byte[BOOT_LOCK_UPPER_BIT],
                                        lock_byte[BOOT_LOCK_LOWER_BIT]); // see (R2) (R3)
  assign store_block_now = store_blocked(lock_byte[BOOT_LOCK_UPPER_BIT],
                                         lock_byte[BOOT_LOCK_LOWER_BIT]);
  // serial writes leave serial enable fuse unchanged
  assign masked_high = prog_serial
    ? {prog_wdata[7:6], fuse_high_byte[SERIAL_DL_BIT], prog_wdata[4:0]}
    : prog_wdata; // see (R9)
  assign fuse_wr_ok = prog_write && lock_byte[MEM_LOCK_FIRST_BIT]; // see (R11)

  // programming mode tracking
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode <= MODE_NORMAL;
    end else begin
      case (mode)
        MODE_NORMAL: if (prog_mode) mode <= MODE_PROG;
        MODE_PROG:   if (!prog_mode) mode <= MODE_LEAVE;
        MODE_LEAVE:  mode <= MODE_NORMAL;
        default:     mode <= MODE_NORMAL;
      endcase
    end
  end

  // stored fuse bytes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fuse_high_byte <= FUSE_HIGH_DEFAULT; // see (R6) (R5)
      fuse_low_byte  <= FUSE_LOW_DEFAULT; // see (R7) (R8)
    end else if (mode == MODE_PROG && fuse_wr_ok && !chip_erase) begin
      if (prog_target == TGT_FUSE_HIGH) fuse_high_byte <= masked_high;
      if (prog_target == TGT_FUSE_LOW) fuse_low_byte <= prog_wdata;
    end
  end

  // lock byte, erased only by chip erase
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lock_byte <= LOCK_DEFAULT;
    end else if (mode == MODE_PROG && chip_erase) begin
      lock_byte <= LOCK_DEFAULT; // see (R10)
    end else if (mode == MODE_PROG && prog_write
                 && prog_target == TGT_LOCK) begin
      lock_byte <= lock_byte & prog_wdata;
    end
  end

  // working latches
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      boot_pending     <= 1'b1;
      fuse_high_active <= FUSE_HIGH_DEFAULT;
      fuse_low_active  <= FUSE_LOW_DEFAULT;
    end else begin
      boot_pending <= 1'b0;
      if ((boot_pending && !prog_mode) // see (R15)
          || (mode == MODE_NORMAL && prog_mode) // see (R13)
          || mode == MODE_LEAVE) begin
        fuse_high_active <= fuse_high_byte;
        fuse_low_active  <= fuse_low_byte;
      end
    end
  end

  // preserve fuse bypasses the latch
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ee_preserve_now <= 1'b0;
    end else begin
      ee_preserve_now <= !fuse_high_byte[EE_PRESERVE_BIT]; // see (R14)
    end
  end

  // chip erase eeprom strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ee_erase <= 1'b0;
    end else begin
      ee_erase <= mode == MODE_PROG && chip_erase
                  && fuse_high_byte[EE_PRESERVE_BIT]
                  && !ee_preserve_now; // see (R16) (R10)
    end
  end

  // programmer read-back
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fuse_high_byte_rd <= FUSE_HIGH_DEFAULT;
      fuse_low_byte_rd  <= FUSE_LOW_DEFAULT;
      lock_rd           <= LOCK_DEFAULT;
    end else begin
      fuse_high_byte_rd <= fuse_high_byte;
      if (prog_serial) fuse_high_byte_rd[SERIAL_DL_BIT] <= 1'b1; // see (R9)
      fuse_low_byte_rd <= fuse_low_byte; // see (R5)
      lock_rd          <= lock_byte;
    end
  end

  // refusal flag for locked fuse writes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      write_refused <= 1'b0;
    end else begin
      write_refused <= mode == MODE_PROG && prog_write
                       && prog_target != TGT_LOCK
                       && !lock_byte[MEM_LOCK_FIRST_BIT]; // see (R11)
    end
  end

  // identification and calibration row
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      id_rd  <= ID_BYTE0;
      cal_rd <= CAL_1MHZ;
    end else begin
      case (id_addr) // see (R17)
        2'h0:    id_rd <= ID_BYTE0;
        2'h1:    id_rd <= ID_BYTE1;
        ID_ADDR_LAST: id_rd <= ID_BYTE2;
        default: id_rd <= 8'hff;
      endcase
      case (id_addr) // see (R18)
        2'h0:    cal_rd <= CAL_1MHZ;
        2'h1:    cal_rd <= CAL_2MHZ;
        2'h2:    cal_rd <= CAL_4MHZ;
        default: cal_rd <= CAL_8MHZ;
      endcase
    end
  end

  // oscillator trim
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      oscillator_trim_register <= CAL_1MHZ; // see (R19)
    end else if (trim_write) begin
      oscillator_trim_register <= trim_wdata;
    end
  end

  // boot section protection
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      store_allow <= 1'b0;
      load_allow  <= 1'b0;
    end else begin
      store_allow <= store_req
                     && !(target_in_boot && store_block_now); // see (R1) (R2) (R3)
      load_allow  <= load_req && !(target_in_boot && !fetch_in_boot
                     && read_block_mode); // see (R2) (R3)
    end
  end

  // interrupt mask while running in boot
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask <= 1'b0;
    end else begin
      irq_mask <= read_block_mode && vectors_in_app
                  && fetch_in_boot; // see (R4)
    end
  end

  // page geometry split
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flash_word_index <= 6'h00;
      flash_page_index <= 7'h00;
      ee_byte_index    <= 2'h0;
      ee_page_index    <= 7'h00;
    end else begin
      flash_word_index <= target_pc[FLASH_WORD_MSB:0]; // see (R20)
      flash_page_index <= target_pc[PC_WIDTH-1:FLASH_WORD_MSB+1];
      ee_byte_index    <= ee_addr[EE_BYTE_MSB:0]; // see (R21)
      ee_page_index    <= ee_addr[EE_ADDR_WIDTH-1:EE_BYTE_MSB+1];
    end
  end

endmodule : fuse_lock_config_store

/* src/fuse_lock_pkg.sv */
package fuse_lock_pkg;

  // fuse high byte fields
  localparam int unsigned DEBUG_EN_BIT     = 7;
  localparam int unsigned TEST_PORT_BIT    = 6;
  localparam int unsigned SERIAL_DL_BIT    = 5;
  localparam int unsigned OSC_OPTION_BIT   = 4;
  localparam int unsigned EE_PRESERVE_BIT  = 3;
  localparam int unsigned BOOT_SIZE_HI_BIT = 2;
  localparam int unsigned BOOT_SIZE_LO_BIT = 1;
  localparam int unsigned RESET_VEC_BIT    = 0;
  // fuse low byte fields
  localparam int unsigned BROWNOUT_LVL_BIT = 7;
  localparam int unsigned BROWNOUT_EN_BIT  = 6;
  localparam int unsigned STARTUP_HI_BIT   = 5;
  localparam int unsigned STARTUP_LO_BIT   = 4;
  localparam int unsigned CLK_SRC_MSB      = 3;
  localparam int unsigned CLK_SRC_LSB      = 0;
  // defaults, programmed reads as 0
  localparam logic [7:0] FUSE_HIGH_DEFAULT = 8'h99;
  localparam logic [7:0] FUSE_LOW_DEFAULT  = 8'he1;
  localparam logic [7:0] LOCK_DEFAULT      = 8'hff;
  // lock byte fields
  localparam int unsigned BOOT_LOCK_UPPER_BIT = 5;
  localparam int unsigned BOOT_LOCK_LOWER_BIT = 4;
  localparam int unsigned MEM_LOCK_FIRST_BIT  = 0;
  // identification row, values arbitrary
  localparam logic [1:0] ID_ADDR_LAST = 2'h2;
  localparam logic [7:0] ID_BYTE0     = 8'h5a;
  localparam logic [7:0] ID_BYTE1     = 8'h42;
  localparam logic [7:0] ID_BYTE2     = 8'h07;
  // calibration bytes for 1, 2, 4, 8 mhz, values arbitrary
  localparam logic [7:0] CAL_1MHZ = 8'h80;
  localparam logic [7:0] CAL_2MHZ = 8'h84;
  localparam logic [7:0] CAL_4MHZ = 8'h88;
  localparam logic [7:0] CAL_8MHZ = 8'h8c;
  // flash and eeprom geometry
  localparam int unsigned PC_WIDTH       = 13;
  localparam int unsigned FLASH_WORD_MSB = 5;
  localparam int unsigned EE_ADDR_WIDTH  = 9;
  localparam int unsigned EE_BYTE_MSB    = 1;
  // boot section start per boot size field
  localparam logic [12:0] BOOT_START_3 = 13'h1f00;
  localparam logic [12:0] BOOT_START_2 = 13'h1e00;
  localparam logic [12:0] BOOT_START_1 = 13'h1c00;
  localparam logic [12:0] BOOT_START_0 = 13'h1c00;
  // programmer target selects
  localparam logic [1:0] TGT_FUSE_LOW  = 2'h0;
  localparam logic [1:0] TGT_FUSE_HIGH = 2'h1;
  localparam logic [1:0] TGT_LOCK      = 2'h2;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_PROG,
    MODE_LEAVE
  } mode_e;

endpackage : fuse_lock_pkg

/* test/fuse_lock_config_store_monitor.sv */
`timescale 1ns/100ps
module fuse_lock_monitor
  import fuse_lock_pkg::*;
(
  // system
  input logic        clock,
  input logic        arst_n,
  // programmer side
  input logic        prog_mode,
  input logic        prog_write,
  input logic [1:0]  prog_target,
  input logic        chip_erase,
  input logic [7:0]  fuse_high_byte_rd,
  input logic [7:0]  lock_rd,
  input logic        write_refused,
  input logic        ee_erase,
  // core side
  input logic [12:0] fetch_pc,
  input logic [12:0] target_pc,
  input logic        store_req,
  input logic        load_req,
  input logic        vectors_in_app,
  input logic [8:0]  ee_addr,
  input logic        store_allow,
  input logic        load_allow,
  input logic        irq_mask,
  input logic [7:0]  oscillator_trim_register,
  input logic [7:0]  fuse_high_active,
  input logic [1:0]  ee_byte_index,
  input logic [6:0]  ee_page_index
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence in_session;
    prog_mode [*4];
  endsequence
  property gated(c, r);
    c && $stable(lock_rd) && $past(lock_rd, 2) == lock_rd
      |=> r || $changed(lock_rd);
  endproperty
  ee_wipe_a: assert property (chip_erase && prog_mode &&
    fuse_high_byte_rd[EE_PRESERVE_BIT] |=> ee_erase) else $error("no wipe");
  ee_keep_a: assert property (chip_erase &&
    !fuse_high_byte_rd[EE_PRESERVE_BIT] |=> !ee_erase) else $error("wiped");
  fuse_freeze_a: assert property (prog_mode && prog_write &&
    prog_target != TGT_LOCK && !lock_rd[MEM_LOCK_FIRST_BIT] |=> write_refused)
    else $error("fuse write not refused");
  lock_clear_a: assert property (chip_erase && prog_mode
    |-> ##3 lock_rd == LOCK_DEFAULT) else $error("locks kept");
  store_free_a: assert property (gated(store_req &&
    lock_rd[5:4] == 2'h3, store_allow)) else $error("store refused");
  store_block_a: assert property (gated(store_req &&
    !lock_rd[BOOT_LOCK_LOWER_BIT] && target_pc >= BOOT_START_3,
    !store_allow)) else $error("boot store allowed");
  load_block_a: assert property (gated(load_req &&
    !lock_rd[BOOT_LOCK_UPPER_BIT] && target_pc >= BOOT_START_3 &&
    fetch_pc < BOOT_START_0, !load_allow)) else $error("boot load allowed");
  irq_off_a: assert property (gated(vectors_in_app &&
    !lock_rd[BOOT_LOCK_UPPER_BIT] && fetch_pc >= BOOT_START_3, irq_mask))
    else $error("irq not masked");
  trim_load_a: assert property ($rose(arst_n) |->
    oscillator_trim_register == CAL_1MHZ) else $error("trim not loaded");
  ee_split_a: assert property (ee_page_index == $past(ee_addr[8:2]) &&
    ee_byte_index == $past(ee_addr[1:0])) else $error("ee split");
  latch_hold_a: assert property (in_session |->
    $stable(fuse_high_active)) else $error("latch moved");
endmodule : fuse_lock_monitor

bind fuse_lock_config_store fuse_lock_monitor mon (.clock, .arst_n,
  .prog_mode, .prog_write, .prog_target, .chip_erase, .fuse_high_byte_rd,
  .lock_rd, .write_refused, .ee_erase, .fetch_pc, .target_pc, .store_req,
  .load_req, .vectors_in_app, .ee_addr, .store_allow, .load_allow, .irq_mask,
  .oscillator_trim_register, .fuse_high_active, .ee_byte_index,
  .ee_page_index);

/* test/programmer_model.sv */
`timescale 1ns/100ps
module programmer_model
  import fuse_lock_pkg::*;
(
  input  logic       clock,
  output logic       prog_mode,
  output logic       prog_serial,
  output logic       prog_write,
  output logic       chip_erase,
  output logic [1:0] prog_target,
  output logic [7:0] prog_wdata
);
  logic fuses_done = 1'b0;
  initial begin
    {prog_mode, prog_serial, prog_write, chip_erase} = 4'h0;
    prog_target = 2'h3;
    prog_wdata = 8'h00;
  end
  task automatic mode(input logic m, input logic s);
    @(negedge clock);
    prog_mode = m;
    prog_serial = s;
    repeat (3) @(negedge clock);
  endtask : mode
  task automatic wr(input logic [1:0] t, input logic [7:0] d);
    if (t == TGT_LOCK && !fuses_done) return;
    if (t != TGT_LOCK) fuses_done = 1'b1;
    @(negedge clock);
    prog_write = 1'b1;
    prog_target = t;
    prog_wdata = d;
    @(negedge clock);
    prog_write = 1'b0;
    prog_target = 2'h3;
    prog_wdata = ~d;
  endtask : wr
  task automatic erase;
    @(negedge clock);
    chip_erase = 1'b1;
    @(negedge clock);
    chip_erase = 1'b0;
  endtask : erase
endmodule : programmer_model

/* test/tb.sv */
`timescale 1ns/100ps
module tb;
  import fuse_lock_pkg::*;
  logic clock, arst_n, prog_mode, prog_serial, prog_write, chip_erase;
  logic store_req, load_req, vectors_in_app, trim_write;
  logic write_refused, ee_erase, store_allow, load_allow, irq_mask;
  logic [1:0] prog_target, id_addr, ee_byte_index;
  logic [7:0] prog_wdata, fuse_high_byte_rd, fuse_low_byte_rd, lock_rd;
  logic [7:0] id_rd, cal_rd, trim_wdata, oscillator_trim_register;
  logic [7:0] fuse_high_active, fuse_low_active;
  logic [12:0] fetch_pc, target_pc;
  logic [8:0] ee_addr;
  logic [5:0] flash_word_index;
  logic [6:0] flash_page_index, ee_page_index;
  logic [7:0] cal_t [4] = '{CAL_1MHZ, CAL_2MHZ, CAL_4MHZ, CAL_8MHZ};
  logic [7:0] id_t [3] = '{ID_BYTE0, ID_BYTE1, ID_BYTE2};
  int err_count = 0;
  int n_tests = 0;
  programmer_model prog (.clock, .prog_mode, .prog_serial, .prog_write,
    .chip_erase, .prog_target, .prog_wdata);
  fuse_lock_config_store dut (.*);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    test_done;
  end
  initial begin
    {arst_n, store_req, load_req, vectors_in_app, trim_write} = 5'h0;
    {id_addr, fetch_pc, target_pc, ee_addr, trim_wdata} = '0;
    tick(6);
    arst_n = 1'b1;
    tick(2);
    check(fuse_high_byte_rd, 8'h99);
    check(fuse_low_byte_rd, 8'he1);
    check(fuse_low_byte_rd[5:0], 6'h21);
    check(fuse_high_active, 8'h99);
    check(fuse_low_active, 8'he1);
    check(oscillator_trim_register, CAL_1MHZ);
    fetch_pc = 13'h1abc;
    target_pc = 13'h1abc;
    ee_addr = 9'h1a7;
    tick(2);
    check(flash_word_index, 6'h3c);
    check(flash_page_index, 7'h6a);
    check(ee_byte_index, 2'h3);
    check(ee_page_index, 7'h69);
    $display("defaults done");
    prog.mode(1'b1, 1'b0);
    prog.erase;
    check(ee_erase, 1'b1);
    prog.wr(TGT_FUSE_HIGH, 8'h91);
    tick(2);
    check(fuse_high_byte_rd, 8'h91);
    check(fuse_high_active, 8'h99);
    prog.erase;
    check(ee_erase, 1'b0);
    prog.mode(1'b1, 1'b1);
    prog.wr(TGT_FUSE_HIGH, 8'hb1);
    tick(2);
    check(fuse_high_byte_rd, 8'hb1);
    prog.mode(1'b1, 1'b0);
    check(fuse_high_byte_rd, 8'h91);
    prog.mode(1'b0, 1'b0);
    check(fuse_high_active, 8'h91);
    $display("session done");
    prog.mode(1'b1, 1'b0);
    prog.wr(TGT_LOCK, 8'hce);
    tick(2);
    check(lock_rd, 8'hce);
    prog.wr(TGT_FUSE_LOW, 8'h00);
    check(write_refused, 1'b1);
    tick(2);
    check(fuse_low_byte_rd, 8'he1);
    target_pc = 13'h1f80;
    fetch_pc = 13'h0100;
    {store_req, load_req} = 2'h3;
    tick(2);
    check(store_allow, 1'b0);
    check(load_allow, 1'b0);
    fetch_pc = 13'h1f10;
    vectors_in_app = 1'b1;
    tick(2);
    check(irq_mask, 1'b1);
    for (int a = 0; a < 4; a++) begin
      id_addr = a[1:0];
      tick(2);
      check(cal_rd, cal_t[a]);
      if (a < 3) check(id_rd, id_t[a]);
      else check(id_rd, 8'hff);
    end
    trim_wdata = CAL_8MHZ;
    trim_write = 1'b1;
    tick(1);
    trim_write = 1'b0;
    tick(1);
    check(oscillator_trim_register, CAL_8MHZ);
    prog.erase;
    tick(3);
    check(lock_rd, 8'hff);
    check(fuse_high_byte_rd, 8'h91);
    check(store_allow, 1'b1);
    check(irq_mask, 1'b0);
    $display("locks done");
    test_done;
  end
endmodule : tb
